// ### core/wbc_regs.sv
// Watchdog and bus control register bank behind the serial port
// Notes on behaviour
// - Watchdog control byte must have even parity over all eight bits.
// - Bit 6 turns watchdog off in Stop; device may set it too.
// - Bit 5 picks time-out (0) or window (1) watchdog.
// - Bit 4 set: bus wake in Stop starts watchdog, long window.
// - Period code 0..6 gives 10 to 1000 ms; code 7 reserved.
// - Reserved bits of these registers always read zero.
// - First bus bit 7 drops LIN slope control up to 115 kBaud.
// - First bus bit 6 selects LIN low-slope mode for 10.4 kBaud.
// - First bus bit 5 enables LIN transmit-data time-out.
// - First bus bits 4:3 set first LIN mode; device may update.
// - First bus bits 1:0 set CAN mode; device may update.
// - Second bus bits 1:0 set second LIN mode; device may update.
// - LIN settings act once chip select rises, for both LINs.
// - Fail-safe loads bus and external wake registers with wake values.
// - Second bus bit 5 selects low or high supply peak threshold.
// - Peak threshold writable in Init and Normal only, not Stop; the code blocks writes in Stop only, so WBC_MODE_OTHER also writes it.
// - Stop-mode peak write raises no failure and no interrupt.
// - Restart keeps watchdog bits 7,5,4, clears 6, loads 3:0 with 0100.
// - Restart keeps LIN settings, clears bit 2, modes from cause.
// - Restart clears second reserved bits, keeps peak, SECOND_SERIAL_BUS_MODE from cause.
// - Watchdog off in Stop needs both stop deactivation bits.
// - Global interrupt bit lets failure status raise the interrupt.
`timescale 1ns/1ps
module wbc_regs
	import wbc_pkg::*;
(
	// System clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// Serial port
	input wire logic sck_in,
	input wire logic chip_select_low_active_in,
	input wire logic mosi_in,
	output logic miso_out,
	output logic miso_oe_out,
	// Device state and events
	input wire wbc_mode_e sbc_mode_in,
	input wire logic enter_restart_in,
	input wire wbc_bus_modes_s restart_modes_in,
	input wire logic enter_failsafe_in,
	input wire logic hw_stop_off_set_in,
	input wire logic hw_modes_upd_in,
	input wire wbc_bus_modes_s hw_modes_in,
	input wire logic bus_wake_in,
	input wire logic int_global_in,
	// Configuration outputs
	output wbc_wd_cfg_s wd_cfg_out,
	output wbc_bus_cfg_s bus_cfg_out,
	output wbc_regs_s regs_out,
	// Event outputs
	output logic wd_long_window_start_out,
	output logic spi_fail_out,
	output logic int_req_out,
	output logic ext_wake_load_out
);
	typedef struct packed {
		logic [15:0] sh;
		logic [4:0] cnt;
		logic [6:0] addr;
		logic done;
	} wbc_sck_s;

	typedef struct packed {
		wbc_regs_s regs;
		wbc_regs_s shadow;
		logic cs_s1;
		logic cs_s2;
		logic cs_s3;
		logic dn_s1;
		logic dn_s2;
		logic pend;
		logic [15:0] word;
		logic fail;
		logic int_req;
		logic long_win;
		logic ext_load;
	} wbc_sys_s;

	function automatic logic [7:0] rd_sel(input wbc_regs_s r,
		input logic [6:0] a);
		logic [7:0] v;
		v = 8'h00;
		if (a == WBC_ADDR_WD) begin
			v = r.wd;
		end else if (a == WBC_ADDR_BC1) begin
			v = r.bc1;
		end else if (a == WBC_ADDR_BC2) begin
			v = r.bc2;
		end else if (a == WBC_ADDR_IWC) begin
			v = r.iwc;
		end
		return v;
	endfunction

	wbc_sck_s sk_q;
	wbc_sck_s sk_d;
	wbc_sys_s st_q;
	wbc_sys_s st_d;
	logic spi_rst_b;
	logic tx_bit;
	logic [7:0] tx_byte;
	logic cs_rise;
	logic commit;
	logic wr_en;
	logic [6:0] wr_addr;
	logic [7:0] wr_data;
	logic wr_par_ok;
	logic wr_per_ok;
	logic [10:0] cur_period_ms;
	logic peak_wr_ok;

	// Frame logic is held in reset while chip select is high
	assign spi_rst_b = rst_b_in & ~chip_select_low_active_in;

	// Link side: shift in LSB first, saturate at a full frame
	always_comb begin
		sk_d = sk_q;
		if (sk_q.cnt != WBC_FRAME_BITS) begin
			sk_d.sh = {mosi_in, sk_q.sh[15:1]};
			sk_d.cnt = sk_q.cnt + 5'h01;
		end
		if (sk_q.cnt == WBC_BYTE_BITS - 5'h01) begin
			sk_d.addr = sk_d.sh[14:8];
		end
		sk_d.done = sk_d.cnt == WBC_FRAME_BITS;
	end

	always_ff @(posedge sck_in or negedge spi_rst_b) begin
		if (!spi_rst_b) begin
			sk_q <= '0;
		end else begin
			sk_q <= sk_d;
		end
	end

	// Reply: status byte, then the addressed register as it stood
	always_comb begin
		tx_bit = 1'b0;
		tx_byte = rd_sel(st_q.shadow, sk_q.addr);
		if (sk_q.cnt < WBC_BYTE_BITS) begin
			tx_bit = WBC_STATUS_BYTE[sk_q.cnt[2:0]];
		end else if (sk_q.cnt < WBC_FRAME_BITS) begin
			tx_bit = tx_byte[sk_q.cnt[2:0]];
		end
	end

	assign miso_out = tx_bit;
	assign miso_oe_out = ~chip_select_low_active_in;

	// Frame decode
	assign cs_rise = st_q.cs_s2 & ~st_q.cs_s3;
	assign commit = cs_rise & st_q.pend;
	assign wr_en = commit & st_q.word[7];
	assign wr_addr = st_q.word[6:0];
	assign wr_data = st_q.word[15:8];
	assign peak_wr_ok = sbc_mode_in != WBC_MODE_STOP;

	wbc_wd_check u_chk_wr (
		.byte_in(wr_data),
		.parity_ok_out(wr_par_ok),
		.period_ok_out(wr_per_ok),
		.period_ms_out()
	);

	wbc_wd_check u_chk_cur (
		.byte_in(st_q.regs.wd),
		.parity_ok_out(),
		.period_ok_out(),
		.period_ms_out(cur_period_ms)
	);

	always_comb begin
		st_d = st_q;
		st_d.cs_s1 = chip_select_low_active_in;
		st_d.cs_s2 = st_q.cs_s1;
		st_d.cs_s3 = st_q.cs_s2;
		st_d.dn_s1 = sk_q.done;
		st_d.dn_s2 = st_q.dn_s1;
		st_d.fail = 1'b0;
		// Capture the frame while chip select is still low
		if (st_q.dn_s2 && !st_q.cs_s2 && !st_q.pend) begin
			st_d.pend = 1'b1;
			st_d.word = sk_q.sh;
		end
		if (commit) begin
			st_d.pend = 1'b0;
		end
		if (wr_en) begin
			if (wr_addr == WBC_ADDR_WD) begin
				if (wr_par_ok && wr_per_ok) begin
					st_d.regs.wd = wr_data & WBC_WMASK_WD;
				end else begin
					st_d.fail = 1'b1;
				end
			end else if (wr_addr == WBC_ADDR_BC1) begin
				st_d.regs.bc1 = wr_data & WBC_WMASK_BC1;
			end else if (wr_addr == WBC_ADDR_BC2) begin
				st_d.regs.bc2 = (wr_data & WBC_WMASK_SECOND_SERIAL_BUS_MODE) |
					((peak_wr_ok ? wr_data : st_q.regs.bc2) &
					WBC_WMASK_PEAK);
			end else if (wr_addr == WBC_ADDR_IWC) begin
				st_d.regs.iwc = wr_data & WBC_WMASK_IWC;
			end
		end
		// Device updates win over a write in the same cycle
		if (hw_stop_off_set_in) begin
			st_d.regs.wd[WBC_WD_STOP_OFF] = 1'b1;
			st_d.regs.iwc[WBC_IWC_STOP_OFF] = 1'b1;
		end
		if (hw_modes_upd_in) begin
			st_d.regs.bc1[WBC_BC1_FIRST_SERIAL_BUS_MODE +: 2] = hw_modes_in.first_serial_bus_mode;
			st_d.regs.bc1[WBC_BC1_CAN +: 2] = hw_modes_in.can;
			st_d.regs.bc2[WBC_BC2_SECOND_SERIAL_BUS_MODE +: 2] = hw_modes_in.second_serial_bus_mode;
		end
		if (enter_restart_in) begin
			st_d.regs.wd = (st_d.regs.wd & WBC_RS_KEEP_WD) |
				WBC_RS_SET_WD;
			st_d.regs.bc1 = (st_d.regs.bc1 & WBC_RS_KEEP_BC1) |
				{3'h0, restart_modes_in.first_serial_bus_mode, 1'b0,
				restart_modes_in.can};
			st_d.regs.bc2 = (st_d.regs.bc2 & WBC_RS_KEEP_BC2) |
				{6'h00, restart_modes_in.second_serial_bus_mode};
			st_d.regs.iwc = st_d.regs.iwc & WBC_RS_KEEP_IWC;
		end
		if (enter_failsafe_in) begin
			st_d.regs.bc1 = (st_d.regs.bc1 & WBC_FS_KEEP_BC1) |
				WBC_FS_SET_BC1;
			st_d.regs.bc2 = WBC_FS_BC2;
		end
		st_d.ext_load = enter_failsafe_in;
		st_d.int_req = st_d.fail & int_global_in;
		st_d.long_win = bus_wake_in &&
			sbc_mode_in == WBC_MODE_STOP &&
			st_q.regs.wd[WBC_WD_BUS_WAKE];
		// Reply copy follows the registers only between frames
		if (st_q.cs_s2) begin
			st_d.shadow = st_q.regs;
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_q <= '0;
			st_q.regs.wd <= WBC_RST_WD;
			st_q.regs.bc1 <= WBC_RST_BC1;
			st_q.regs.bc2 <= WBC_RST_BC2;
			st_q.regs.iwc <= WBC_RST_IWC;
			st_q.shadow.wd <= WBC_RST_WD;
			st_q.shadow.bc1 <= WBC_RST_BC1;
			st_q.shadow.bc2 <= WBC_RST_BC2;
			st_q.shadow.iwc <= WBC_RST_IWC;
			st_q.cs_s1 <= 1'b1;
			st_q.cs_s2 <= 1'b1;
			st_q.cs_s3 <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs
	always_comb begin
		wd_cfg_out.window = st_q.regs.wd[WBC_WD_WINDOW];
		wd_cfg_out.bus_wake_start = st_q.regs.wd[WBC_WD_BUS_WAKE];
		wd_cfg_out.stop_off = st_q.regs.wd[WBC_WD_STOP_OFF] &
			st_q.regs.iwc[WBC_IWC_STOP_OFF];
		wd_cfg_out.period_ms = cur_period_ms;
		bus_cfg_out.flash = st_q.regs.bc1[WBC_BC1_FLASH];
		bus_cfg_out.low_slope = st_q.regs.bc1[WBC_BC1_LSM];
		bus_cfg_out.txd_timeout = st_q.regs.bc1[WBC_BC1_TXD_TO];
		bus_cfg_out.modes.first_serial_bus_mode = st_q.regs.bc1[WBC_BC1_FIRST_SERIAL_BUS_MODE +: 2];
		bus_cfg_out.modes.can = st_q.regs.bc1[WBC_BC1_CAN +: 2];
		bus_cfg_out.modes.second_serial_bus_mode = st_q.regs.bc2[WBC_BC2_SECOND_SERIAL_BUS_MODE +: 2];
		bus_cfg_out.peak_high = st_q.regs.bc2[WBC_BC2_PEAK];
	end

	assign regs_out = st_q.regs;
	assign wd_long_window_start_out = st_q.long_win;
	assign spi_fail_out = st_q.fail;
	assign int_req_out = st_q.int_req;
	assign ext_wake_load_out = st_q.ext_load;

	// Checks
	AST_RESERVED_ZERO: assert property (@(posedge clk_in)
		disable iff (!rst_b_in)
		st_q.regs.wd[3] == 1'b0 && st_q.regs.bc1[2] == 1'b0 &&
		(st_q.regs.bc2 & 8'hdc) == 8'h00 &&
		(st_q.regs.iwc & 8'h3b) == 8'h00)
		else $error("Reserved bit set");

	AST_PARITY_REJECT: assert property (@(posedge clk_in)
		disable iff (!rst_b_in)
		wr_en && wr_addr == WBC_ADDR_WD && !wr_par_ok |=>
		spi_fail_out && int_req_out == $past(int_global_in))
		else $error("Odd parity write not rejected");

	AST_PERIOD_LEGAL: assert property (@(posedge clk_in)
		disable iff (!rst_b_in)
		st_q.regs.wd[2:0] != WBC_PERIOD_RSVD)
		else $error("Reserved period code stored");

	AST_PEAK_STOP_HELD: assert property (@(posedge clk_in)
		disable iff (!rst_b_in)
		wr_en && wr_addr == WBC_ADDR_BC2 &&
		sbc_mode_in == WBC_MODE_STOP && !enter_failsafe_in |=>
		$stable(bus_cfg_out.peak_high))
		else $error("Peak bit changed in Stop");

	AST_PEAK_STOP_QUIET: assert property (@(posedge clk_in)
		disable iff (!rst_b_in)
		wr_en && wr_addr == WBC_ADDR_BC2 |=>
		!spi_fail_out && !int_req_out)
		else $error("Peak write raised a failure");

	AST_LONG_WINDOW: assert property (@(posedge clk_in)
		disable iff (!rst_b_in)
		bus_wake_in && sbc_mode_in == WBC_MODE_STOP |=>
		wd_long_window_start_out == $past(st_q.regs.wd[4]))
		else $error("Bus wake start wrong");

	AST_RESTART_WD: assert property (@(posedge clk_in)
		disable iff (!rst_b_in)
		enter_restart_in && !wr_en |=>
		st_q.regs.wd[7] == $past(st_q.regs.wd[7]) &&
		st_q.regs.wd[5:4] == $past(st_q.regs.wd[5:4]) &&
		st_q.regs.wd[6] == 1'b0 && st_q.regs.wd[3:0] == 4'h4)
		else $error("Restart watchdog value wrong");

	AST_FAILSAFE: assert property (@(posedge clk_in)
		disable iff (!rst_b_in)
		enter_failsafe_in |=> st_q.regs.bc2 == 8'h01 &&
		st_q.regs.bc1[4:0] == 5'h09 && ext_wake_load_out)
		else $error("Fail-safe values wrong");

	AST_LIN_COMMIT: assert property (@(posedge clk_in)
		disable iff (!rst_b_in)
		$rose(st_q.cs_s2) && st_q.pend && st_q.word[7] &&
		st_q.word[6:0] == WBC_ADDR_BC1 && !enter_failsafe_in &&
		!enter_restart_in |=>
		bus_cfg_out.flash == $past(st_q.word[15]) &&
		bus_cfg_out.low_slope == $past(st_q.word[14]))
		else $error("LIN setting not applied at deselect");

	AST_STOP_OFF_BOTH: assert property (@(posedge clk_in)
		disable iff (!rst_b_in)
		wd_cfg_out.stop_off |-> st_q.regs.iwc[2] && st_q.regs.wd[6])
		else $error("Stop deactivation without both bits");

	AST_INT_GATE: assert property (@(posedge clk_in)
		disable iff (!rst_b_in)
		int_req_out |-> spi_fail_out && $past(int_global_in))
		else $error("Interrupt without global enable");
endmodule // wbc_regs

// ### core/wbc_pkg.sv
// Constants and types for the watchdog and bus control register bank
package wbc_pkg;
	// Register addresses
	localparam logic [6:0] WBC_ADDR_WD = 7'h03;
	localparam logic [6:0] WBC_ADDR_BC1 = 7'h04;
	localparam logic [6:0] WBC_ADDR_BC2 = 7'h05;
	localparam logic [6:0] WBC_ADDR_IWC = 7'h06;
	// Reset values
	localparam logic [7:0] WBC_RST_WD = 8'h14;
	localparam logic [7:0] WBC_RST_BC1 = 8'h20;
	localparam logic [7:0] WBC_RST_BC2 = 8'h00;
	localparam logic [7:0] WBC_RST_IWC = 8'h00;
	// Field positions
	localparam int WBC_WD_STOP_OFF = 6;
	localparam int WBC_WD_WINDOW = 5;
	localparam int WBC_WD_BUS_WAKE = 4;
	localparam int WBC_WD_PERIOD = 0;
	localparam int WBC_BC1_FLASH = 7;
	localparam int WBC_BC1_LSM = 6;
	localparam int WBC_BC1_TXD_TO = 5;
	localparam int WBC_BC1_FIRST_SERIAL_BUS_MODE = 3;
	localparam int WBC_BC1_CAN = 0;
	localparam int WBC_BC2_PEAK = 5;
	localparam int WBC_BC2_SECOND_SERIAL_BUS_MODE = 0;
	localparam int WBC_IWC_STOP_OFF = 2;
	// Writable bit masks, reserved bits excluded
	localparam logic [7:0] WBC_WMASK_WD = 8'hf7;
	localparam logic [7:0] WBC_WMASK_BC1 = 8'hfb;
	localparam logic [7:0] WBC_WMASK_SECOND_SERIAL_BUS_MODE = 8'h03;
	localparam logic [7:0] WBC_WMASK_PEAK = 8'h20;
	localparam logic [7:0] WBC_WMASK_IWC = 8'hc4;
	// Restart values: kept bits and loaded bits
	localparam logic [7:0] WBC_RS_KEEP_WD = 8'hb0;
	localparam logic [7:0] WBC_RS_SET_WD = 8'h04;
	localparam logic [7:0] WBC_RS_KEEP_BC1 = 8'he0;
	localparam logic [7:0] WBC_RS_KEEP_BC2 = 8'h20;
	localparam logic [7:0] WBC_RS_KEEP_IWC = 8'hc0;
	// Fail-safe values
	localparam logic [7:0] WBC_FS_KEEP_BC1 = 8'he0;
	localparam logic [7:0] WBC_FS_SET_BC1 = 8'h09;
	localparam logic [7:0] WBC_FS_BC2 = 8'h01;
	localparam logic [7:0] WBC_FS_KEEP_EXT = 8'ha0;
	localparam logic [7:0] WBC_FS_SET_EXT = 8'h07;
	// Watchdog period codes and times in ms
	localparam logic [2:0] WBC_PERIOD_RSVD = 3'h7;
	localparam int WBC_PERIOD_MS [0:6] = '{10, 20, 50, 100, 200, 500, 1000};
	// Serial frame
	localparam logic [4:0] WBC_FRAME_BITS = 5'h10;
	localparam logic [4:0] WBC_BYTE_BITS = 5'h08;
	localparam logic [7:0] WBC_STATUS_BYTE = 8'h00;

	typedef enum logic [1:0] {
		WBC_MODE_INIT,
		WBC_MODE_NORMAL,
		WBC_MODE_STOP,
		WBC_MODE_OTHER
	} wbc_mode_e;

	typedef struct packed {
		logic [7:0] wd;
		logic [7:0] bc1;
		logic [7:0] bc2;
		logic [7:0] iwc;
	} wbc_regs_s;

	typedef struct packed {
		logic [1:0] first_serial_bus_mode;
		logic [1:0] can;
		logic [1:0] second_serial_bus_mode;
	} wbc_bus_modes_s;

	typedef struct packed {
		logic flash;
		logic low_slope;
		logic txd_timeout;
		wbc_bus_modes_s modes;
		logic peak_high;
	} wbc_bus_cfg_s;

	typedef struct packed {
		logic window;
		logic bus_wake_start;
		logic stop_off;
		logic [10:0] period_ms;
	} wbc_wd_cfg_s;
endpackage

// ### core/wbc_wd_check.sv
// Parity and period check for a watchdog control byte
`timescale 1ns/1ps
module wbc_wd_check
	import wbc_pkg::*;
(
	// Byte under test
	input wire logic [7:0] byte_in,
	// Results
	output logic parity_ok_out,
	output logic period_ok_out,
	output logic [10:0] period_ms_out
);
	function automatic logic [10:0] period_ms(input logic [2:0] code);
		logic [10:0] r;
		r = 11'h000;
		if (code != WBC_PERIOD_RSVD) begin
			r = 11'(WBC_PERIOD_MS[code]);
		end
		return r;
	endfunction

	always_comb begin
		parity_ok_out = ~^byte_in;
		period_ok_out = byte_in[2:0] != WBC_PERIOD_RSVD;
		period_ms_out = period_ms(byte_in[2:0]);
	end
endmodule // wbc_wd_check

// ### tb/wbc_host.sv
// Host model driving serial frames into the register bank
`timescale 1ns/1ps
module wbc_host (
	// System clock
	input wire logic clk_in,
	// Serial port
	output logic sck_out,
	output logic chip_select_low_active_out,
	output logic mosi_out,
	input wire logic miso_in
);
	initial begin
		sck_out = 1'b0;
		chip_select_low_active_out = 1'b1;
		mosi_out = 1'b0;
	end

	// One 16 bit frame, LSB first, serial clock only inside the frame
	task automatic xfer(input logic [6:0] a, input logic w,
		input logic [7:0] d, input logic fix, output logic [7:0] r);
		logic [15:0] f;
		logic [7:0] rd;
		f = {d, w, a};
		rd = 8'h00;
		if (fix && a == 7'h03) f[15] = ^f[14:8];
		@(posedge clk_in) chip_select_low_active_out <= 1'b0;
		repeat (5) @(posedge clk_in);
		#1.3;
		for (int i = 0; i < 16; i++) begin
			mosi_out = f[i];
			#3 sck_out = 1'b1;
			#2;
			if (i > 6 && i < 15) rd[i - 7] = miso_in;
			#1 sck_out = 1'b0;
		end
		mosi_out = ~mosi_out;
		r = rd;
		repeat (4) @(posedge clk_in);
		chip_select_low_active_out <= 1'b1;
		repeat (8) @(posedge clk_in);
	endtask
endmodule // wbc_host

// ### tb/tb.sv
// Self-checking bench for the watchdog and bus control register bank
`timescale 1ns/1ps
module tb
	import wbc_pkg::*;
;
	logic clk_in, rst_b_in, sck, csb, mosi, miso, int_global;
	logic lws, fail, intr, extl;
	logic [4:0] ev;
	logic [7:0] rd;
	wbc_mode_e mode;
	wbc_bus_modes_s rs_modes, hw_modes;
	wbc_wd_cfg_s wd_cfg;
	wbc_bus_cfg_s bus_cfg;
	wbc_regs_s regs;
	int mismatches, samples_checked, n_fail, n_int, n_lws, n_ext;

	wbc_regs uut (.clk_in(clk_in), .rst_b_in(rst_b_in), .sck_in(sck),
		.chip_select_low_active_in(csb), .mosi_in(mosi), .miso_out(miso),
		.miso_oe_out(), .sbc_mode_in(mode), .enter_restart_in(ev[0]),
		.restart_modes_in(rs_modes), .enter_failsafe_in(ev[1]),
		.hw_stop_off_set_in(ev[2]), .hw_modes_upd_in(ev[3]),
		.hw_modes_in(hw_modes), .bus_wake_in(ev[4]),
		.int_global_in(int_global), .wd_cfg_out(wd_cfg),
		.bus_cfg_out(bus_cfg), .regs_out(regs),
		.wd_long_window_start_out(lws), .spi_fail_out(fail),
		.int_req_out(intr), .ext_wake_load_out(extl));

	wbc_host host (.clk_in(clk_in), .sck_out(sck),
		.chip_select_low_active_out(csb), .mosi_out(mosi), .miso_in(miso));

	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	always @(posedge clk_in) begin
		n_fail += (fail === 1'b1);
		n_int += (intr === 1'b1);
		n_lws += (lws === 1'b1);
		n_ext += (extl === 1'b1);
	end

	task automatic chk(input string nm, input logic [39:0] seen,
		input logic [39:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] d,
		input logic fix = 1'b1);
		host.xfer(a, 1'b1, d, fix, rd);
	endtask

	task automatic pulse(input int i);
		@(posedge clk_in) ev[i] <= 1'b1;
		@(posedge clk_in) ev <= 5'h00;
		repeat (3) @(posedge clk_in);
	endtask

	task automatic setmode(input wbc_mode_e m);
		@(posedge clk_in) mode <= m;
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk_in);
		mismatches++;
		conclude();
	end

	initial begin
		rst_b_in = 1'b0;
		ev = 5'h00;
		mode = WBC_MODE_NORMAL;
		rs_modes = 6'h18;
		hw_modes = 6'h27;
		int_global = 1'b0;
		{mismatches, samples_checked, n_fail, n_int, n_lws, n_ext} = '0;
		repeat (3) @(posedge clk_in);
		rst_b_in <= 1'b1;
		repeat (5) @(posedge clk_in);
		chk("reset regs", regs, 32'h14200000);
		chk("reset wd cfg", wd_cfg, {3'b010, 11'd200});
		host.xfer(7'h03, 1'b0, 8'h00, 1'b0, rd);
		chk("read wd", rd, 8'h14);
		for (int c = 0; c < 7; c++) begin
			wr(7'h03, {5'h0a, c[2:0]});
			chk("wd reg", regs.wd, {^c[2:0], 4'ha, c[2:0]});
			chk("wd cfg", wd_cfg, {3'b010, 11'(WBC_PERIOD_MS[c])});
		end
		wr(7'h03, 8'h01, 1'b0);
		chk("odd parity", regs.wd, 8'h56);
		chk("no int", n_int, 0);
		@(posedge clk_in) int_global <= 1'b1;
		wr(7'h03, 8'h87, 1'b0);
		chk("period 7", regs.wd, 8'h56);
		chk("fail count", n_fail, 2);
		chk("int count", n_int, 1);
		wr(7'h04, 8'hff);
		chk("bc1 all", regs.bc1, 8'hfb);
		chk("bus cfg", bus_cfg, 10'h3f8);
		for (int m = 0; m < 4; m++) begin
			wr(7'h04, {3'h0, m[1:0], 1'b1, m[1:0]});
			wr(7'h05, {6'h3f, m[1:0]});
			chk("bc1 mode", regs.bc1, {3'h0, m[1:0], 1'b0, m[1:0]});
			chk("bc2 mode", regs.bc2, {6'h08, m[1:0]});
		end
		host.xfer(7'h05, 1'b0, 8'h00, 1'b0, rd);
		chk("read bc2", rd, 8'h23);
		setmode(WBC_MODE_STOP);
		wr(7'h05, 8'h00);
		chk("stop peak", regs.bc2, 8'h20);
		chk("stop no fail", n_fail + n_int, 3);
		wr(7'h03, 8'h90);
		pulse(4);
		setmode(WBC_MODE_NORMAL);
		pulse(4);
		setmode(WBC_MODE_STOP);
		wr(7'h03, 8'h00);
		pulse(4);
		chk("wake starts", n_lws, 1);
		wr(7'h06, 8'hff);
		chk("iwc", regs.iwc, 8'hc4);
		chk("one stop bit", wd_cfg.stop_off, 1'b0);
		pulse(2);
		chk("hw stop", {regs.wd, regs.iwc}, 16'h40c4);
		chk("both stop", wd_cfg.stop_off, 1'b1);
		wr(7'h04, 8'hf7);
		pulse(3);
		chk("hw modes", bus_cfg.modes, 6'h27);
		chk("hw bc1", regs.bc1, 8'hf1);
		pulse(0);
		chk("restart", regs, 32'h04ea20c0);
		pulse(1);
		chk("failsafe", {regs.bc1, regs.bc2}, 16'he901);
		chk("ext wake", n_ext, 1);
		wr(7'h20, 8'hff);
		host.xfer(7'h20, 1'b0, 8'h00, 1'b0, rd);
		chk("unmapped", {rd, regs}, 40'h0004e901c0);
		wr(7'h03, 8'h25);
		chk("window", wd_cfg, {3'b100, 11'd500});
		setmode(WBC_MODE_INIT);
		wr(7'h05, 8'h20);
		chk("init peak", regs.bc2, 8'h20);
		conclude();
	end
endmodule // tb
